// ---- pkg/indicator_map.svh ----
`ifndef INDICATOR_MAP_SVH
`define INDICATOR_MAP_SVH

// register indices; byte address is four times the index
`define IDX_FUNC_SELECT 8'h16
`define IDX_RATE_QUALIFY 8'h18
`define IDX_OVERRIDE 8'h19

// reset values
`define RST_FUNC_SELECT 16'h0a54
`define RST_RATE_QUALIFY 16'h0000
`define RST_OVERRIDE 16'h0000
`define RST_PIN 3'h7

// writable bits; everything else reads as zero
`define MASK_FUNC_SELECT 16'h0fff
`define MASK_RATE_QUALIFY 16'h7fff
`define MASK_OVERRIDE 16'h703f

// field positions and widths per indicator
`define FUNC_W 4
`define RATE_W 3
`define OVR_W 2
`define POL_LSB 12
`define BLINK_LSB 9
`define STRETCH_LSB 12

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// timing
`define CLK_PERIOD_PS 5000
`define MS_IN_PS 1000000000
`define MS_CYCLES (`MS_IN_PS / `CLK_PERIOD_PS)
`define BLINK_PERIOD_MS 84
`define BLINK_HALF_MS (`BLINK_PERIOD_MS / 2)
`define STRETCH_MS 170

`endif

// ---- pkg/indicator_pkg.sv ----
`default_nettype none
package indicator_pkg;

   // state-driven source selection
   typedef enum logic [3:0] {
      fn_collision = 4'h0,
      fn_error = 4'h1,
      fn_duplex = 4'h2,
      fn_duplex_col = 4'h3,
      fn_speed = 4'h4,
      fn_link = 4'h5,
      fn_tx = 4'h6,
      fn_rx = 4'h7,
      fn_activity = 4'h8,
      fn_link_rx = 4'h9,
      fn_link_act = 4'ha,
      fn_act_blink = 4'hb,
      fn_tx_blink = 4'hc,
      fn_rx_blink = 4'hd,
      fn_special = 4'he,
      fn_off = 4'hf
   } func_code_t;

   // software override
   typedef enum logic [1:0] {
      ovr_normal = 2'h0,
      ovr_blink = 2'h1,
      ovr_off = 2'h2,
      ovr_on = 2'h3
   } override_t;

   // speed qualification; other codes are reserved
   typedef enum logic [2:0] {
      rate_10 = 3'h0,
      rate_100 = 3'h5,
      rate_off = 3'h6
   } rate_qualify_t;

   typedef struct packed {
      logic [31:0] ms_cnt;
      logic [15:0] blink_ms;
      logic [15:0] stretch_ms;
      logic blink_phase;
      logic stretch_tick;
   } timer_state_t;

   typedef struct packed {
      logic [15:0] func_sel;
      logic [15:0] rate_sel;
      logic [15:0] override;
      logic aw_held;
      logic [7:0] aw_index;
      logic w_held;
      logic [15:0] w_data;
      logic [1:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] age;
      logic [2:0] pin;
   } ctrl_state_t;

endpackage
`default_nettype wire

// ---- pkg/indicator_timer_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface indicator_timer_if;
   logic [2:0] blink_code; // blink period select
   logic [2:0] stretch_code; // stretch unit select
   logic blink_phase; // shared blink square wave
   logic stretch_tick; // one-cycle pulse per stretch unit
   modport timer (input blink_code, input stretch_code, output blink_phase, output stretch_tick);
   modport user (output blink_code, output stretch_code, input blink_phase, input stretch_tick);
endinterface
`default_nettype wire

// ---- core/indicator_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "indicator_map.svh"
module indicator_timer #(
   parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   indicator_timer_if.timer tmr
);
   indicator_pkg::timer_state_t st; // registered state
   indicator_pkg::timer_state_t next_st; // next state
   logic ms_tick; // one millisecond elapsed
   logic [15:0] blink_last; // last count of a half period
   logic [15:0] stretch_last; // last count of a stretch unit

   // half period grows with the code so the default gives the nominal period
   assign blink_last = 16'(`BLINK_HALF_MS * ({13'h0000, tmr.blink_code} + 16'h0001) - 1);
   assign stretch_last = 16'(`STRETCH_MS * ({13'h0000, tmr.stretch_code} + 16'h0001) - 1);
   assign ms_tick = (st.ms_cnt == 32'(MS_CYCLES - 1));
   assign tmr.blink_phase = st.blink_phase;
   assign tmr.stretch_tick = st.stretch_tick;

   // millisecond prescaler feeding both timers
   always_comb
   begin
      next_st = st;
      next_st.stretch_tick = 1'b0;
      next_st.ms_cnt = ms_tick ? 32'h0000_0000 : st.ms_cnt + 32'h0000_0001;
      if (ms_tick)
      begin
         // code changes apply to the running half period, a shrink wraps at once
         if (st.blink_ms >= blink_last)
         begin
            next_st.blink_ms = 16'h0000;
            next_st.blink_phase = ~st.blink_phase;
         end
         else
         begin
            next_st.blink_ms = st.blink_ms + 16'h0001;
         end
         if (st.stretch_ms >= stretch_last)
         begin
            next_st.stretch_ms = 16'h0000;
            next_st.stretch_tick = 1'b1;
         end
         else
         begin
            next_st.stretch_ms = st.stretch_ms + 16'h0001;
         end
      end
   end

   // synchronous reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         st <= '0;
      else
         st <= next_st;
   end
endmodule
`default_nettype wire

// ---- core/status_indicator_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "indicator_map.svh"
module status_indicator_control #(
   parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [9:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [9:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic link_up,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic tx_event,
   input wire logic rx_event,
   input wire logic collision_indication,
   input wire logic error_event,
   input wire logic interrupt_pending,
   output logic [2:0] indicator_pin
);
   localparam indicator_pkg::ctrl_state_t ST_RESET = '{
      func_sel: `RST_FUNC_SELECT,
      rate_sel: `RST_RATE_QUALIFY,
      override: `RST_OVERRIDE,
      pin: `RST_PIN,
      default: '0
   };

   indicator_pkg::ctrl_state_t st; // registered state
   indicator_pkg::ctrl_state_t next_st; // next state
   indicator_timer_if tmr_if (); // link to the shared timers
   logic [3:0] event_in; // collision, error, tx, rx
   logic [3:0] stretched; // events held visible
   logic traffic_activity; // stretched tx or rx
   logic [2:0] lit; // indicator active, before polarity
   logic [15:0] rd_word; // read mux result
   logic rd_hit; // read address is mapped
   logic [15:0] wr_old; // register under write
   logic [15:0] wr_mask; // its writable bits
   logic wr_hit; // write address is mapped
   logic [15:0] wr_merged; // strobe-merged write value

   // shared blink wave and stretch tick
   indicator_timer #(
      .MS_CYCLES(MS_CYCLES)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .tmr(tmr_if.timer)
   );

   // timer codes straight from the speed-qualify register
   assign tmr_if.blink_code = st.rate_sel[`BLINK_LSB +: 3];
   assign tmr_if.stretch_code = st.rate_sel[`STRETCH_LSB +: 3];

   // event sources, all on aclk so no synchroniser
   assign event_in = {rx_event, tx_event, error_event, collision_indication};

   // an event is visible while its age is non-zero
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_stretch
         assign stretched[g] = |st.age[2*g +: 2];
      end
   endgenerate
   assign traffic_activity = stretched[2] | stretched[3];

   // state-driven decode for one indicator
   function automatic logic decode_source(
      input int unsigned idx,
      input logic [3:0] code,
      input logic [2:0] rate,
      input logic blink,
      input logic link,
      input logic fast,
      input logic duplex,
      input logic irq,
      input logic [3:0] ev,
      input logic act
   );
      logic on;
      on = 1'b0;
      unique case (indicator_pkg::func_code_t'(code))
         indicator_pkg::fn_collision: on = ev[0];
         indicator_pkg::fn_error: on = ev[1];
         indicator_pkg::fn_duplex: on = duplex;
         // half duplex blinks on collision, full duplex steady
         indicator_pkg::fn_duplex_col: on = duplex | (ev[0] & blink);
         indicator_pkg::fn_speed:
         begin
            // reserved qualify codes leave the indicator dark
            case (indicator_pkg::rate_qualify_t'(rate))
               indicator_pkg::rate_10: on = link & ~fast;
               indicator_pkg::rate_100: on = link & fast;
               default: on = 1'b0;
            endcase
         end
         indicator_pkg::fn_link: on = link;
         indicator_pkg::fn_tx: on = ev[2];
         indicator_pkg::fn_rx: on = ev[3];
         // indicator 0 has no activity or link/rx mode
         indicator_pkg::fn_activity: on = (idx != 0) & act;
         indicator_pkg::fn_link_rx: on = (idx != 0) & link & ~(ev[3] & ~blink);
         // steady on link, dark half of the blink while traffic runs
         indicator_pkg::fn_link_act: on = link & ~(act & ~blink);
         indicator_pkg::fn_act_blink: on = act & blink;
         indicator_pkg::fn_tx_blink: on = ev[2] & blink;
         indicator_pkg::fn_rx_blink: on = ev[3] & blink;
         // indicator 2 shows interrupt, the others blink collision
         indicator_pkg::fn_special: on = (idx == 2) ? irq : (ev[0] & blink);
         indicator_pkg::fn_off: on = 1'b0;
      endcase
      return on;
   endfunction

   // per-indicator override and source selection
   generate
      for (g = 0; g < 3; g++)
      begin : g_indicator
         logic [1:0] ovr;
         logic state_on;
         assign ovr = st.override[`OVR_W*g +: `OVR_W];
         assign state_on = decode_source(g, st.func_sel[`FUNC_W*g +: `FUNC_W],
            st.rate_sel[`RATE_W*g +: `RATE_W], tmr_if.blink_phase, link_up,
            speed_100, full_duplex, interrupt_pending, stretched, traffic_activity);
         // each indicator picks its own path
         always_comb
         begin
            unique case (indicator_pkg::override_t'(ovr))
               indicator_pkg::ovr_normal: lit[g] = state_on;
               indicator_pkg::ovr_blink: lit[g] = tmr_if.blink_phase;
               indicator_pkg::ovr_off: lit[g] = 1'b0;
               indicator_pkg::ovr_on: lit[g] = 1'b1;
            endcase
         end
      end
   endgenerate

   // read mux; reserved bits already zero in storage
   always_comb
   begin
      rd_hit = 1'b1;
      unique case (araddr[9:2])
         `IDX_FUNC_SELECT: rd_word = st.func_sel;
         `IDX_RATE_QUALIFY: rd_word = st.rate_sel;
         `IDX_OVERRIDE: rd_word = st.override;
         default:
         begin
            rd_word = 16'h0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // write target and its writable bits
   always_comb
   begin
      wr_hit = 1'b1;
      unique case (st.aw_index)
         `IDX_FUNC_SELECT:
         begin
            wr_old = st.func_sel;
            wr_mask = `MASK_FUNC_SELECT;
         end
         `IDX_RATE_QUALIFY:
         begin
            wr_old = st.rate_sel;
            wr_mask = `MASK_RATE_QUALIFY;
         end
         `IDX_OVERRIDE:
         begin
            wr_old = st.override;
            wr_mask = `MASK_OVERRIDE;
         end
         default:
         begin
            wr_old = 16'h0000;
            wr_mask = 16'h0000;
            wr_hit = 1'b0;
         end
      endcase
   end

   // byte lanes 0 and 1 carry the 16-bit registers
   always_comb
   begin
      wr_merged = wr_old;
      if (st.w_strb[0])
         wr_merged[7:0] = st.w_data[7:0];
      if (st.w_strb[1])
         wr_merged[15:8] = st.w_data[15:8];
      wr_merged = wr_merged & wr_mask;
   end

   // handshake outputs; the slave takes one write and one read at a time
   assign awready = ~st.aw_held & ~st.bvalid;
   assign wready = ~st.w_held & ~st.bvalid;
   assign arready = ~st.rvalid;
   assign bvalid = st.bvalid;
   assign bresp = st.bresp;
   assign rvalid = st.rvalid;
   assign rdata = st.rdata;
   assign rresp = st.rresp;
   assign indicator_pin = st.pin;

   // whole next state
   always_comb
   begin
      next_st = st;
      // address and data are collected in either order
      if (awvalid && awready)
      begin
         next_st.aw_held = 1'b1;
         next_st.aw_index = awaddr[9:2];
      end
      if (wvalid && wready)
      begin
         next_st.w_held = 1'b1;
         next_st.w_data = wdata[15:0];
         next_st.w_strb = wstrb[1:0];
      end
      // both halves present: commit and answer
      if (st.aw_held && st.w_held)
      begin
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         if (st.aw_index == `IDX_FUNC_SELECT)
            next_st.func_sel = wr_merged;
         if (st.aw_index == `IDX_RATE_QUALIFY)
            next_st.rate_sel = wr_merged;
         if (st.aw_index == `IDX_OVERRIDE)
            next_st.override = wr_merged;
      end
      if (st.bvalid && bready)
         next_st.bvalid = 1'b0;
      // reads answer one cycle after the address is taken
      if (arvalid && arready)
      begin
         next_st.rvalid = 1'b1;
         next_st.rdata = {16'h0000, rd_word};
         next_st.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (st.rvalid && rready)
         next_st.rvalid = 1'b0;
      // age 2 on an event, down one per tick: held 1 to 2 units
      for (int i = 0; i < 4; i++)
      begin
         if (event_in[i])
            next_st.age[2*i +: 2] = 2'h2;
         else if (tmr_if.stretch_tick && stretched[i])
            next_st.age[2*i +: 2] = st.age[2*i +: 2] - 2'h1;
      end
      // polarity applied last, so forced modes obey it too
      next_st.pin = ~(lit ^ st.override[`POL_LSB +: 3]);
   end

   // synchronous reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         st <= ST_RESET;
      else
         st <= next_st;
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_FORCE_ON_2: assert property (
      (st.override[5:4] == 2'h3) |=> (indicator_pin[2] == $past(st.override[14])))
      else $error("forced-on indicator 2 not at active level");

   AST_FORCE_OFF_1: assert property (
      (st.override[3:2] == 2'h2) |=> (indicator_pin[1] == ~$past(st.override[13])))
      else $error("forced-off indicator 1 not at idle level");

   AST_BLINK_0: assert property (
      (st.override[1:0] == 2'h1)
      |=> (indicator_pin[0] == ~($past(tmr_if.blink_phase) ^ $past(st.override[12]))))
      else $error("blinking indicator 0 does not follow the blink wave");

   AST_LINK_2: assert property (
      (st.override[5:4] == 2'h0 && st.func_sel[11:8] == 4'h5)
      |=> (indicator_pin[2] == ~($past(link_up) ^ $past(st.override[14]))))
      else $error("indicator 2 does not follow link");

   AST_SPECIAL_1: assert property (
      (st.override[3:2] == 2'h0 && st.func_sel[7:4] == 4'he && !stretched[0])
      |=> (indicator_pin[1] == ~$past(st.override[13])))
      else $error("indicator 1 lit in collision blink mode without collision");

   AST_NO_ACT_0: assert property (
      (st.override[1:0] == 2'h0 && st.func_sel[3:1] == 3'h4)
      |=> (indicator_pin[0] == ~$past(st.override[12])))
      else $error("indicator 0 lit by an undefined code");

   AST_RATE_OFF_1: assert property (
      (st.override[3:2] == 2'h0 && st.func_sel[7:4] == 4'h4 && st.rate_sel[5:3] == 3'h6)
      |=> (indicator_pin[1] == ~$past(st.override[13])))
      else $error("speed indicator 1 lit while qualified off");

   AST_STRETCH_2: assert property (
      (collision_indication && st.override[5:4] == 2'h0 && st.func_sel[11:8] == 4'h0)
      ##1 (st.override[5:4] == 2'h0 && st.func_sel[11:8] == 4'h0)
      |=> (indicator_pin[2] == $past(st.override[14], 2)))
      else $error("collision not stretched onto indicator 2");

   AST_LINK_ACT_0: assert property (
      (st.override[1:0] == 2'h0 && st.func_sel[3:0] == 4'ha && link_up && !traffic_activity)
      |=> (indicator_pin[0] == $past(st.override[12])))
      else $error("link/activity indicator 0 not steady on idle link");

   AST_WRITE_RESP: assert property (
      (st.aw_held && st.w_held) |=> (bvalid && $stable(st.aw_held) == 1'b0))
      else $error("write not answered one cycle after collection");
endmodule
`default_nettype wire

// ---- sim/indicator_lamp.sv ----
`timescale 1ns/1ps
`default_nettype none
module indicator_lamp (
   input wire logic pin, // board line level
   input wire logic active_high, // level at which the lamp glows
   output logic lit // lamp glows
);
   // a lamp glows only at its active level; an unknown line stays dark
   assign lit = (pin === active_high);
endmodule
`default_nettype wire

// ---- sim/status_indicator_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module status_indicator_control_test;
   localparam int MS = 4; // cycles per ms tick, shortened
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [9:0] awaddr = 10'h000;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hf;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [9:0] araddr = 10'h000;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic link_up = 1'b0;
   logic speed_100 = 1'b0;
   logic full_duplex = 1'b0;
   logic tx_event = 1'b0;
   logic rx_event = 1'b0;
   logic collision_indication = 1'b0;
   logic error_event = 1'b0;
   logic interrupt_pending = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [2:0] indicator_pin;
   logic [2:0] pol = 3'h0; // polarity last written
   logic [2:0] lit; // lamp states seen on the board
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   logic [1:0] r;
   logic [31:0] d;
   int n;
   status_indicator_control #(.MS_CYCLES(MS)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .link_up(link_up), .speed_100(speed_100),
      .full_duplex(full_duplex), .tx_event(tx_event), .rx_event(rx_event),
      .collision_indication(collision_indication), .error_event(error_event),
      .interrupt_pending(interrupt_pending), .indicator_pin(indicator_pin));
   // one lamp per indicator line
   indicator_lamp u_lamp[2:0] (.pin(indicator_pin), .active_high(pol), .lit(lit));
   // 200 MHz clock
   always #2.5 aclk = ~aclk;
   // hang guard, well above the longest sequence
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         error_cnt++;
         conclude();
      end
   end
   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask
   // compare and count; four-state so unknowns fail
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask
   // axi write: both halves offered together, each released when taken
   task automatic wr(input logic [9:0] a, input logic [15:0] v, output logic [1:0] rs);
      logic aw_p;
      logic w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      awaddr <= a;
      wdata <= {16'h0000, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (aw_p || w_p)
      begin
         @(posedge aclk);
         if (aw_p && awready === 1'b1)
         begin
            aw_p = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_p && wready === 1'b1)
         begin
            w_p = 1'b0;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   // axi read; the extra edge keeps strobes from being re-driven in one step
   task automatic rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] rs);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   // override register write keeps the lamps' polarity in step
   task automatic ovr(input logic [15:0] v);
      wr(10'h064, v, r);
      pol = v[14:12];
   endtask
   // status levels: link, duplex, interrupt, tx, rx, error
   task automatic st(input logic [5:0] s);
      {link_up, full_duplex, interrupt_pending, tx_event, rx_event, error_event} <= s;
   endtask
   task automatic t_regs;
      rd(10'h058, d, r);
      chk("func_reset", 32'h0000_0a54, d);
      chk("rresp_okay", 32'(2'h0), 32'(r));
      rd(10'h060, d, r);
      chk("rate_reset", 32'h0000_0000, d);
      rd(10'h064, d, r);
      chk("ovr_reset", 32'h0000_0000, d);
      rd(10'h000, d, r);
      chk("unmapped_rresp", 32'(2'h2), 32'(r));
      wr(10'h004, 16'hffff, r);
      chk("unmapped_bresp", 32'(2'h2), 32'(r));
      wr(10'h058, 16'hffff, r);
      chk("bresp_okay", 32'(2'h0), 32'(r));
      rd(10'h058, d, r);
      chk("func_mask", 32'h0000_0fff, d);
      // only lane 0 written: the upper byte must survive
      wstrb <= 4'h1;
      wr(10'h058, 16'h0000, r);
      wstrb <= 4'hf;
      rd(10'h058, d, r);
      chk("func_strobe", 32'h0000_0f00, d);
      wr(10'h058, 16'h0a54, r);
   endtask
   // each field alone forced off then on, others follow the lit or dark status
   task automatic t_override;
      for (int i = 0; i < 3; i++)
         for (int c = 2; c < 4; c++)
         begin
            // forced off against a lit status, forced on against a dark one
            st((c == 2) ? 6'h20 : 6'h00);
            ovr(16'(c) << (2 * i));
            cyc(3);
            chk("override", (c == 3) ? 32'(3'h1 << i) : 32'(3'h7 ^ (3'h1 << i)), 32'(lit));
         end
      ovr(16'h0030);
      st(6'h20);
      cyc(3);
      chk("forced_and_link", 32'(3'h7), 32'(lit));
      st(6'h00);
      cyc(3);
      chk("forced_no_link", 32'(3'h4), 32'(lit));
      ovr(16'h703f);
      cyc(3);
      chk("pin_on_high", 32'(3'h7), 32'(indicator_pin));
      ovr(16'h502a);
      cyc(3);
      chk("pin_off_mixed", 32'(3'h2), 32'(indicator_pin));
      ovr(16'h0000);
   endtask
   // function select with a status pattern and the lamps expected
   task automatic fn(input logic [15:0] f, input logic [5:0] s, input logic [2:0] e);
      wr(10'h058, f, r);
      st(s);
      cyc(3);
      chk("function", 32'(e), 32'(lit));
      st(6'h00);
   endtask
   task automatic t_function;
      fn(16'h0fff, 6'h3f, 3'h0);
      fn(16'h0555, 6'h20, 3'h7);
      fn(16'h0222, 6'h10, 3'h7);
      fn(16'h0eff, 6'h08, 3'h4);
      fn(16'h0888, 6'h04, 3'h6);
      fn(16'h0666, 6'h04, 3'h7);
      fn(16'h0777, 6'h02, 3'h7);
      fn(16'h0111, 6'h01, 3'h7);
      fn(16'h0444, 6'h20, 3'h7);
      speed_100 <= 1'b1;
      fn(16'h0444, 6'h20, 3'h0);
      wr(10'h060, 16'h016d, r);
      fn(16'h0444, 6'h20, 3'h7);
      wr(10'h060, 16'h01b6, r);
      fn(16'h0444, 6'h20, 3'h0);
      wr(10'h060, 16'h0000, r);
      speed_100 <= 1'b0;
   endtask
   // cycles until the next change of indicator 0
   task automatic gap(output int k);
      logic s;
      s = indicator_pin[0];
      k = 0;
      while (indicator_pin[0] === s)
      begin
         @(posedge aclk);
         k++;
      end
   endtask
   task automatic t_blink;
      ovr(16'h0015);
      gap(n);
      gap(n);
      chk("blink_half_default", 32'(42 * MS), 32'(n));
      wr(10'h060, 16'h0200, r);
      gap(n);
      gap(n);
      chk("blink_half_code1", 32'(84 * MS), 32'(n));
      wr(10'h060, 16'h0000, r);
      ovr(16'h0000);
   endtask
   // one-cycle collision held for one to two stretch units
   task automatic t_stretch;
      wr(10'h058, 16'h0000, r);
      collision_indication <= 1'b1;
      @(posedge aclk);
      collision_indication <= 1'b0;
      cyc(660);
      chk("stretch_held", 32'(3'h7), 32'(lit));
      cyc(720);
      chk("stretch_gone", 32'(3'h0), 32'(lit));
   endtask
   // steady while linked, blinking dark while traffic is stretched
   task automatic t_link_act;
      int dark;
      dark = 0;
      // no stretched event left here, so the blink modes stay dark
      fn(16'h0bcd, 6'h20, 3'h0);
      fn(16'h0eee, 6'h08, 3'h4);
      fn(16'h0999, 6'h20, 3'h6);
      fn(16'h0333, 6'h10, 3'h7);
      wr(10'h058, 16'h0aaa, r);
      st(6'h20);
      cyc(3);
      repeat (400)
      begin
         @(posedge aclk);
         dark += (lit[0] === 1'b1) ? 0 : 1;
      end
      chk("linkact_steady", 32'h0, 32'(dark));
      st(6'h24);
      @(posedge aclk);
      st(6'h20);
      repeat (400)
      begin
         @(posedge aclk);
         dark += (lit[0] === 1'b1) ? 0 : 1;
      end
      chk("linkact_blinks", 32'h1, 32'(dark > 0));
      st(6'h00);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      cyc(8);
      chk("pin_in_reset", 32'(3'h7), 32'(indicator_pin));
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_override();
      t_function();
      t_blink();
      t_stretch();
      t_link_act();
      conclude();
   end
endmodule
`default_nettype wire
